//--- srap_defines.vh
// constants shared by the serial register access port
// assumes inclusion by bare name from the four-wire engine and top design files
`ifndef SRAP_DEFINES_VH
`define SRAP_DEFINES_VH
// strap level that selects the four-wire mode
`define SRAP_STRAP_SPI 1'h1
// fixed upper bits of the two-wire slave address
`define SRAP_ADDR_FIXED 4'h5
// high-speed master code, upper five bits
`define SRAP_HS_CODE 5'h01
// data bits per two-wire transfer unit
`define SRAP_BYTE_BITS 4'h8
// four-wire frame: rising edges after the command and in total
`define SRAP_SPI_CMD_BITS 5'h08
`define SRAP_SPI_FRAME_BITS 5'h18
// four-wire read word: leading bits forced high
`define SRAP_SPI_PAD 4'hf
// position of the read flag in a command byte
`define SRAP_CMD_READ_BIT 7
`endif

//--- srap_sync.v
// two flip-flop synchroniser for a group of pin inputs
// assumes inputs asynchronous to clk; ce freezes both stages
`timescale 1ns/1ps
module srap_sync #(
  parameter W = 7
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst,
  input  wire         ce,
  // pins in, synchronised levels out
  input  wire [W-1:0] asyncIn,
  output reg  [W-1:0] syncOut
);

  reg [W-1:0] meta_reg;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= {W{1'b1}};
      syncOut  <= {W{1'b1}};
    end
    else if (ce)
    begin
      meta_reg <= asyncIn;
      syncOut  <= meta_reg;
    end
  end

endmodule

//--- srap_spi.v
// four-wire slave engine: 24-bit frames, command then 16 data bits
// assumes synchronised pin levels and edge pulses from the top
`timescale 1ns/1ps
`include "srap_defines.vh"
module srap_spi (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  // mode gate and pin views
  input  wire        enable,
  input  wire        csN,
  input  wire        sclkRise,
  input  wire        sclkFall,
  input  wire        dinBit,
  // serial output
  output reg         doutBit,
  output reg         doutOe,
  // register side
  output reg         wrStb,
  output reg         rdStb,
  output reg  [6:0]  regAddr,
  output reg  [15:0] wrData,
  input  wire [15:0] regRdData
);

  reg [4:0]  riseCnt_reg;
  reg [15:0] shiftIn_reg;
  reg [7:0]  cmd_reg;
  reg [15:0] txWord_reg;
  reg        active_reg;

  wire [7:0]  cmdNow  = {shiftIn_reg[6:0], dinBit};
  wire [15:0] rdFirst = {`SRAP_SPI_PAD, regRdData[11:0]};

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      riseCnt_reg <= 5'h00;
      shiftIn_reg <= 16'h0000;
      cmd_reg     <= 8'h00;
      txWord_reg  <= 16'h0000;
      active_reg  <= 1'b0;
      doutBit     <= 1'b0;
      doutOe      <= 1'b0;
      wrStb       <= 1'b0;
      rdStb       <= 1'b0;
      regAddr     <= 7'h00;
      wrData      <= 16'h0000;
    end
    else if (ce)
    begin
      wrStb <= 1'b0;
      rdStb <= 1'b0;
      if (!enable || csN)
      begin
        // write executes only after a full frame, then chip select high or enable low
        if (active_reg && riseCnt_reg == `SRAP_SPI_FRAME_BITS && !cmd_reg[`SRAP_CMD_READ_BIT]) // see RL21
        begin
          wrStb   <= 1'b1;
          regAddr <= cmd_reg[6:0];
          wrData  <= shiftIn_reg[15:0];
        end
        // early deselect: output off at once, read dropped, frame restarts
        riseCnt_reg <= 5'h00; // see RL22
        doutOe      <= 1'b0; // see RL22
        active_reg  <= 1'b0;
        cmd_reg     <= 8'h00;
      end
      else
      begin
        active_reg <= 1'b1;
        doutOe     <= 1'b1;
        // input sampled on rising clock edges, command byte first
        if (sclkRise && riseCnt_reg != `SRAP_SPI_FRAME_BITS) // see RL2
        begin
          shiftIn_reg <= {shiftIn_reg[14:0], dinBit};
          riseCnt_reg <= riseCnt_reg + 5'h01;
          if (riseCnt_reg == `SRAP_SPI_CMD_BITS - 5'h01)
          begin
            cmd_reg <= cmdNow;
            if (cmdNow[`SRAP_CMD_READ_BIT])
            begin
              rdStb   <= 1'b1;
              regAddr <= cmdNow[6:0];
            end
          end
        end
        // output changes on falling clock edges
        if (sclkFall && cmd_reg[`SRAP_CMD_READ_BIT]) // see RL4
        begin
          if (riseCnt_reg == `SRAP_SPI_CMD_BITS)
          begin
            doutBit    <= rdFirst[15]; // see RL3
            txWord_reg <= {rdFirst[14:0], 1'b0};
          end
          else if (riseCnt_reg > `SRAP_SPI_CMD_BITS && riseCnt_reg != `SRAP_SPI_FRAME_BITS)
          begin
            doutBit    <= txWord_reg[15];
            txWord_reg <= {txWord_reg[14:0], 1'b0};
          end
        end
      end
    end
  end

endmodule

//--- srap_top.v
// serial register access port: two-wire slave or four-wire slave
// assumes pins asynchronous to clk; register file sits outside
//
// Behaviour
// RL1: strap low two-wire, strap high four-wire
// RL2: four-wire command sampled on rising clock
// RL3: four-wire read word leads with four ones
// RL4: four-wire output changes on falling clock
// RL5: two-wire rates up to 400k and 3.4M
// RL6: two-wire unit: eight bits plus acknowledge
// RL7: data change with clock high is control
// RL8: fall with clock high START, rise STOP
// RL9: acknowledge low through ninth clock high phase
// RL10: matching address acknowledged for one clock
// RL11: address is 0101 plus three select pins
// RL12: fast mode after power-up
// RL13: master code: not-acknowledge, then high-speed
// RL14: STOP leaves high-speed, repeated START keeps it
// RL15: write command byte top bit zero, acknowledged
// RL16: two data bytes acknowledged, then STOP
// RL17: read: command top bit one, then restart
// RL18: read address: device sends two register bytes
// RL19: master ends read with not-acknowledge, STOP
// RL20: bare read address returns last read register
// RL21: four-wire frame 24 bits, select held low
// RL22: early deselect tristates output, drops read
// RL23: foreign address: stay released until START
`timescale 1ns/1ps
`include "srap_defines.vh"
module srap_top (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  // interface strap
  input  wire        modeSelectStrap,
  // shared serial clock and data pins
  input  wire        serialClkIn,
  input  wire        serialDataIn,
  output reg         sdaOut,
  output reg         sdaOe,
  // address select pins
  input  wire        addr_select_bit0,
  input  wire        addr_select_bit1,
  input  wire        addr_select_bit2,
  // four-wire select and output
  input  wire        csN,
  output reg         doutOut,
  output reg         doutOe,
  // register side
  output reg         regWrStb,
  output reg         regRdStb,
  output reg  [6:0]  regAddr,
  output reg  [15:0] regWrData,
  input  wire [15:0] regRdData,
  // status
  output reg         hsModeActive,
  output reg         modeSpiActive
);

  // ************************************************************
  // pin synchronisation and edge finding
  // ************************************************************
  localparam ST_IDLE   = 3'h0;
  localparam ST_RX     = 3'h1;
  localparam ST_ACK    = 3'h2;
  localparam ST_TX     = 3'h3;
  localparam ST_MACK   = 3'h4;
  localparam ST_NEXT   = 3'h5;
  localparam ST_IGNORE = 3'h6;

  wire [6:0] pinSync;
  reg  [1:0] prev_reg;

  // sampling at clk keeps many samples per high-speed bit
  srap_sync #(
    .W (7)
  ) u_sync (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .asyncIn ({modeSelectStrap, addr_select_bit2, addr_select_bit1, addr_select_bit0,
               csN, serialDataIn, serialClkIn}),
    .syncOut (pinSync)
  ); // see RL5

  wire       sclS    = pinSync[0];
  wire       sdaS    = pinSync[1];
  wire       csS     = pinSync[2];
  wire [2:0] addrSel = pinSync[5:3];
  wire       strapS  = pinSync[6];

  wire sclRise = sclS & ~prev_reg[0];
  wire sclFall = ~sclS & prev_reg[0];
  wire sdaRise = sdaS & ~prev_reg[1];
  wire sdaFall = ~sdaS & prev_reg[1];

  // data edges while the clock stays high are bus conditions
  wire i2cStart = sdaFall & sclS & prev_reg[0]; // see RL7
  wire i2cStop  = sdaRise & sclS & prev_reg[0]; // see RL8

  wire [6:0] ownAddr = {`SRAP_ADDR_FIXED, addrSel}; // see RL11

  always @(posedge clk or posedge rst)
  begin
    if (rst)
      prev_reg <= 2'h3;
    else if (ce)
      prev_reg <= {sdaS, sclS};
  end

  // ************************************************************
  // four-wire engine
  // ************************************************************
  wire        spiDout;
  wire        spiDoutOe;
  wire        spiWr;
  wire        spiRd;
  wire [6:0]  spiAddr;
  wire [15:0] spiData;

  srap_spi u_spi (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .enable    (modeSpiActive),
    .csN       (csS),
    .sclkRise  (sclRise),
    .sclkFall  (sclFall),
    .dinBit    (sdaS),
    .doutBit   (spiDout),
    .doutOe    (spiDoutOe),
    .wrStb     (spiWr),
    .rdStb     (spiRd),
    .regAddr   (spiAddr),
    .wrData    (spiData),
    .regRdData (regRdData)
  );

  // ************************************************************
  // two-wire engine
  // ************************************************************
  reg [2:0]  state_reg;
  reg [3:0]  bitCnt_reg;
  reg [1:0]  byteIdx_reg;
  reg [7:0]  shift_reg;
  reg [15:0] txWord_reg;
  reg [7:0]  cmd_reg;
  reg [7:0]  wrHi_reg;
  reg [6:0]  lastRead_reg;
  reg        readDir_reg;
  reg        masterCode_reg;
  reg        txLow_reg;
  reg        i2cWr_reg;
  reg        i2cRd_reg;
  reg [6:0]  i2cAddr_reg;
  reg        sdaDrive_reg;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg      <= ST_IDLE;
      bitCnt_reg     <= 4'h0;
      byteIdx_reg    <= 2'h0;
      shift_reg      <= 8'h00;
      txWord_reg     <= 16'h0000;
      cmd_reg        <= 8'h00;
      wrHi_reg       <= 8'h00;
      lastRead_reg   <= 7'h00;
      readDir_reg    <= 1'b0;
      masterCode_reg <= 1'b0;
      txLow_reg      <= 1'b0;
      i2cWr_reg      <= 1'b0;
      i2cRd_reg      <= 1'b0;
      i2cAddr_reg    <= 7'h00;
      sdaDrive_reg   <= 1'b0;
      hsModeActive   <= 1'b0; // see RL12
    end
    else if (ce)
    begin
      i2cWr_reg <= 1'b0;
      i2cRd_reg <= 1'b0;
      if (modeSpiActive)
      begin
        state_reg    <= ST_IDLE;
        sdaDrive_reg <= 1'b0;
        hsModeActive <= 1'b0;
      end
      else if (i2cStop)
      begin
        state_reg    <= ST_IDLE;
        sdaDrive_reg <= 1'b0;
        hsModeActive <= 1'b0; // see RL14
      end
      else if (i2cStart)
      begin
        // repeated start leaves the speed mode alone
        state_reg    <= ST_RX; // see RL14
        bitCnt_reg   <= 4'h0;
        byteIdx_reg  <= 2'h0;
        sdaDrive_reg <= 1'b0;
      end
      else
      begin
        case (state_reg)
          ST_RX:
          begin
            if (sclRise && bitCnt_reg != `SRAP_BYTE_BITS)
            begin
              shift_reg  <= {shift_reg[6:0], sdaS};
              bitCnt_reg <= bitCnt_reg + 4'h1; // see RL6
            end
            else if (sclFall && bitCnt_reg == `SRAP_BYTE_BITS)
            begin
              // drive before the ninth rising edge
              bitCnt_reg     <= 4'h0;
              state_reg      <= ST_ACK; // see RL9
              masterCode_reg <= 1'b0;
              case (byteIdx_reg)
                2'h0:
                begin
                  if (shift_reg[7:1] == ownAddr)
                  begin
                    sdaDrive_reg <= 1'b1; // see RL10
                    readDir_reg  <= shift_reg[0];
                    if (shift_reg[0])
                    begin
                      // last read register, new or default read
                      i2cRd_reg   <= 1'b1; // see RL20
                      i2cAddr_reg <= lastRead_reg;
                    end
                  end
                  else if (shift_reg[7:3] == `SRAP_HS_CODE)
                    masterCode_reg <= 1'b1; // see RL13
                  else
                    state_reg <= ST_IGNORE; // see RL23
                end
                2'h1:
                begin
                  cmd_reg      <= shift_reg; // see RL15
                  sdaDrive_reg <= 1'b1; // see RL15
                  if (shift_reg[`SRAP_CMD_READ_BIT])
                    lastRead_reg <= shift_reg[6:0]; // see RL17
                end
                2'h2:
                begin
                  wrHi_reg     <= shift_reg;
                  sdaDrive_reg <= ~cmd_reg[`SRAP_CMD_READ_BIT]; // see RL16
                end
                default:
                begin
                  sdaDrive_reg <= ~cmd_reg[`SRAP_CMD_READ_BIT]; // see RL16
                  if (!cmd_reg[`SRAP_CMD_READ_BIT])
                  begin
                    i2cWr_reg   <= 1'b1;
                    i2cAddr_reg <= cmd_reg[6:0];
                  end
                end
              endcase
            end
          end
          ST_ACK:
          begin
            // release at the end of the ninth clock
            if (sclFall)
            begin
              sdaDrive_reg <= 1'b0; // see RL9
              if (masterCode_reg)
              begin
                hsModeActive <= 1'b1; // see RL13
                state_reg    <= ST_IGNORE;
              end
              else if (byteIdx_reg == 2'h0 && readDir_reg)
              begin
                // take the data line and send the high byte first
                state_reg    <= ST_TX; // see RL18
                txWord_reg   <= {regRdData[14:0], 1'b0};
                sdaDrive_reg <= ~regRdData[15]; // see RL18
                txLow_reg    <= 1'b0;
              end
              else if (byteIdx_reg == 2'h3 || (byteIdx_reg == 2'h2 && cmd_reg[`SRAP_CMD_READ_BIT]))
                state_reg <= ST_IGNORE;
              else
              begin
                state_reg   <= ST_RX;
                byteIdx_reg <= byteIdx_reg + 2'h1;
              end
            end
          end
          ST_TX:
          begin
            if (sclRise)
              bitCnt_reg <= bitCnt_reg + 4'h1;
            else if (sclFall)
            begin
              if (bitCnt_reg == `SRAP_BYTE_BITS)
              begin
                sdaDrive_reg <= 1'b0; // see RL6
                state_reg    <= ST_MACK;
              end
              else
              begin
                sdaDrive_reg <= ~txWord_reg[15];
                txWord_reg   <= {txWord_reg[14:0], 1'b0};
              end
            end
          end
          ST_MACK:
          begin
            // master acknowledge after the high byte continues; not-acknowledge or the low byte ends the read
            if (sclRise)
            begin
              if (!sdaS && !txLow_reg)
                state_reg <= ST_NEXT;
              else
                state_reg <= ST_IGNORE; // see RL19
            end
          end
          ST_NEXT:
          begin
            if (sclFall)
            begin
              state_reg    <= ST_TX;
              bitCnt_reg   <= 4'h0;
              txLow_reg    <= 1'b1;
              sdaDrive_reg <= ~txWord_reg[15];
              txWord_reg   <= {txWord_reg[14:0], 1'b0};
            end
          end
          ST_IDLE:
            sdaDrive_reg <= 1'b0;
          ST_IGNORE:
            sdaDrive_reg <= 1'b0; // see RL23
          default:
          begin
            state_reg    <= ST_IDLE;
            sdaDrive_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // output registers and mode selection
  // ************************************************************
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      modeSpiActive <= 1'b0;
      sdaOut        <= 1'b0;
      sdaOe         <= 1'b0;
      doutOut       <= 1'b0;
      doutOe        <= 1'b0;
      regWrStb      <= 1'b0;
      regRdStb      <= 1'b0;
      regAddr       <= 7'h00;
      regWrData     <= 16'h0000;
    end
    else if (ce)
    begin
      modeSpiActive <= (strapS == `SRAP_STRAP_SPI); // see RL1
      sdaOut        <= 1'b0;
      sdaOe         <= sdaDrive_reg & ~modeSpiActive;
      doutOut       <= spiDout;
      doutOe        <= spiDoutOe & modeSpiActive;
      if (modeSpiActive)
      begin
        regWrStb <= spiWr;
        regRdStb <= spiRd;
        if (spiWr || spiRd)
          regAddr <= spiAddr;
        if (spiWr)
          regWrData <= spiData;
      end
      else
      begin
        regWrStb <= i2cWr_reg;
        regRdStb <= i2cRd_reg;
        if (i2cWr_reg || i2cRd_reg)
          regAddr <= i2cAddr_reg;
        if (i2cWr_reg)
          regWrData <= {wrHi_reg, shift_reg};
      end
    end
  end

endmodule

//--- srap_asserts.sv
// checker: pin timing relations of srap_top
// assumes bind from the testbench file
`timescale 1ns/1ps
module srap_asserts (
  // clock and reset
  input wire clk,
  input wire rst,
  // link pins
  input wire serialClkIn,
  input wire serialDataIn,
  input wire csN,
  input wire sdaOe,
  input wire doutOut,
  input wire doutOe,
  // strobes and status
  input wire regWrStb,
  input wire regRdStb,
  input wire hsModeActive,
  input wire modeSpiActive
);
  // ****
  // assertions
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_spi_no_sda: assert property (modeSpiActive |-> !sdaOe)
    else $error("data pin pulled in four-wire mode");
  chk_i2c_no_dout: assert property (!modeSpiActive && !$past(modeSpiActive) |-> !doutOe)
    else $error("serial output driven in two-wire mode");
  chk_cs_tristate: assert property (csN [*7] |-> !doutOe)
    else $error("serial output driven while deselected");
  chk_dout_fall: assert property (doutOe && $past(doutOe) && $changed(doutOut) |-> !serialClkIn)
    else $error("serial output changed with clock high");
  chk_sda_scl_low: assert property ($changed(sdaOe) |-> !serialClkIn)
    else $error("data pull changed with clock high");
  chk_ack_len: assert property ($rose(sdaOe) |=> sdaOe [*8] ##[1:150] !sdaOe)
    else $error("data pull too short or too long");
  chk_hs_enter: assert property ($rose(hsModeActive) |-> !modeSpiActive && !$past(serialClkIn, 2))
    else $error("speed mode entered off the low clock phase");
  chk_hs_leave: assert property ($fell(hsModeActive) |-> serialClkIn && serialDataIn)
    else $error("speed mode left without stop");
  chk_wr_pulse: assert property (regWrStb |=> !regWrStb)
    else $error("write strobe longer than one cycle");
  chk_rd_pulse: assert property (regRdStb |=> !regRdStb)
    else $error("read strobe longer than one cycle");
  chk_spi_wr_cs: assert property (regWrStb && modeSpiActive |-> csN)
    else $error("four-wire write before deselect");
endmodule

//--- srap_host.sv
// partner: host controller as two-wire and four-wire master
// assumes the testbench resolves the data wire
`timescale 1ns/1ps
module srap_host (
  // pins driven by the host
  output reg  sclk,
  output reg  sdaM,
  output reg  csN,
  // pins seen by the host
  input  wire sdaWire,
  input  wire doutOut,
  input  wire doutOe
);
  // ****
  // bus cycles
  // ****
  initial
  begin
    sclk = 1'h1;
    sdaM = 1'h1;
    csN  = 1'h1;
  end
  task startCond;
    begin
      if (!sclk)
      begin
        #32 sdaM = 1'h1;
        #33 sclk = 1'h1;
      end
      #40 sdaM = 1'h0;
      #40 sclk = 1'h0;
    end
  endtask
  task stopCond;
    begin
      #32 sdaM = 1'h0;
      #33 sclk = 1'h1;
      #40 sdaM = 1'h1;
      #200;
    end
  endtask
  task bitCycle(input v, output s);
    begin
      #32 sdaM = v;
      #33 sclk = 1'h1;
      #30 s = sdaWire;
      #30 sclk = 1'h0;
    end
  endtask
  task sendByte(input [7:0] b, output ack);
    integer i;
    reg     s;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bitCycle(b[i], s);
      bitCycle(1'h1, s);
      ack = !s;
    end
  endtask
  task recvByte(input ackIt, output [7:0] b);
    integer i;
    reg     s;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bitCycle(1'h1, b[i]);
      bitCycle(!ackIt, s);
    end
  endtask
  task spiFrame(input [23:0] w, input integer nRise, output [15:0] rd);
    integer i;
    begin
      sclk = 1'h0;
      #40 csN = 1'h0;
      for (i = 0; i < nRise; i = i + 1)
      begin
        sdaM = w[23-i];
        #65 sclk = 1'h1;
        if (i > 7)
          rd[23-i] = doutOe ? doutOut : 1'hx;
        #60 sclk = 1'h0;
      end
      #65 csN = 1'h1;
      sdaM = !sdaM;
      #100;
    end
  endtask
endmodule

//--- srap_tb.sv
// testbench: random and corner transfers in both link modes
// assumes srap_top, srap_host and srap_asserts compiled first
`timescale 1ns/1ps
module testbench;
  reg         clk;
  reg         rst;
  reg         strap;
  reg  [2:0]  pinAddr;
  reg  [15:0] regRdData;
  reg  [31:0] seed;
  reg  [22:0] wrWord;
  reg  [15:0] rd;
  reg  [15:0] ex;
  reg  [3:0]  ak;
  integer     wrCount;
  integer     rdCount;
  integer     cnt0;
  integer     i;
  integer     num_errors;
  integer     n_tests;
  wire        sclk, sdaM, csN, sdaOut, sdaOe, doutOut, doutOe;
  wire        regWrStb, regRdStb, hsModeActive, modeSpiActive;
  wire [6:0]  regAddr;
  wire [15:0] regWrData;
  // open-drain data wire with pull-up
  wire        sdaWire = sdaM & ~(sdaOe & ~sdaOut);
  srap_top DUT (.clk(clk), .rst(rst), .ce(1'h1), .modeSelectStrap(strap),
    .serialClkIn(sclk), .serialDataIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addr_select_bit0(pinAddr[0]), .addr_select_bit1(pinAddr[1]), .addr_select_bit2(pinAddr[2]),
    .csN(csN), .doutOut(doutOut), .doutOe(doutOe), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .hsModeActive(hsModeActive), .modeSpiActive(modeSpiActive));
  srap_host host (.sclk(sclk), .sdaM(sdaM), .csN(csN), .sdaWire(sdaWire), .doutOut(doutOut), .doutOe(doutOe));
  // ****
  // models and helpers
  // ****
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  function [15:0] rdModel(input [6:0] a);
    rdModel = {~a[3:0], a, 5'h15};
  endfunction
  always @(posedge clk)
  begin
    if (regWrStb)
    begin
      wrCount <= wrCount + 1;
      wrWord  <= {regAddr, regWrData};
    end
    if (regRdStb)
      rdCount <= rdCount + 1;
  end
  always @(negedge clk)
    regRdData <= rdModel(regAddr);
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task check(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task i2cWrite(input [6:0] dev, input [6:0] r, input [15:0] d, output [3:0] a);
    begin
      host.startCond;
      host.sendByte({dev, 1'h0}, a[3]);
      host.sendByte({1'h0, r}, a[2]);
      host.sendByte(d[15:8], a[1]);
      host.sendByte(d[7:0], a[0]);
      host.stopCond;
    end
  endtask
  task i2cRead(input five, input [6:0] r, output [15:0] d, output [3:0] a);
    begin
      a = 4'hf;
      host.startCond;
      if (five)
      begin
        host.sendByte({4'h5, pinAddr, 1'h0}, a[2]);
        host.sendByte({1'h1, r}, a[1]);
        host.startCond;
      end
      host.sendByte({4'h5, pinAddr, 1'h1}, a[0]);
      host.recvByte(1'h1, d[15:8]);
      host.recvByte(1'h0, d[7:0]);
      host.stopCond;
    end
  endtask
  // ****
  // tests
  // ****
  initial
  begin
    #200000;
    num_errors = num_errors + 1;
    wrap_up;
  end
  initial
  begin
    rst = 1'h1;
    strap = 1'h0;
    pinAddr = 3'h0;
    regRdData = 16'h0;
    seed = 32'h21c4338c;
    wrCount = 0;
    rdCount = 0;
    num_errors = 0;
    n_tests = 0;
    repeat (2) @(negedge clk);
    rst = 1'h0;
    repeat (8) @(negedge clk);
    check(hsModeActive, 0);
    check(modeSpiActive, 0);
    for (i = 0; i < 4; i = i + 1)
    begin
      seed = xs(seed);
      pinAddr = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : seed[2:0];
      cnt0 = wrCount;
      i2cWrite({4'h5, pinAddr}, seed[10:4], seed[31:16], ak);
      check(ak, 4'hf);
      check(wrCount - cnt0, 1);
      check(wrWord, {seed[10:4], seed[31:16]});
    end
    for (i = 0; i < 2; i = i + 1)
    begin
      cnt0 = wrCount;
      i2cWrite(i ? {4'ha, pinAddr} : {4'h5, ~pinAddr}, 7'h01, 16'h1234, ak);
      check(ak, 4'h0);
      check(wrCount - cnt0, 0);
    end
    $display("write test done");
    seed = xs(seed);
    ex = rdModel(seed[6:0]);
    cnt0 = rdCount;
    i2cRead(1'h1, seed[6:0], rd, ak);
    check(ak, 4'hf);
    check(rdCount - cnt0, 1);
    check(regAddr, seed[6:0]);
    check(rd, ex);
    i2cWrite({4'h5, pinAddr}, ~seed[6:0], 16'h0f0f, ak);
    i2cRead(1'h0, 7'h0, rd, ak);
    check(ak, 4'hf);
    check(rd, ex);
    $display("read test done");
    host.startCond;
    host.sendByte({5'h01, seed[9:7]}, ak[0]);
    repeat (8) @(negedge clk);
    check(ak[0], 0);
    check(hsModeActive, 1);
    host.startCond;
    host.sendByte({4'h5, pinAddr, 1'h0}, ak[0]);
    check(ak[0], 1);
    check(hsModeActive, 1);
    host.stopCond;
    check(hsModeActive, 0);
    $display("speed mode test done");
    strap = 1'h1;
    repeat (6) @(negedge clk);
    check(modeSpiActive, 1);
    for (i = 0; i < 2; i = i + 1)
    begin
      seed = xs(seed);
      cnt0 = wrCount;
      host.spiFrame({1'h0, seed[6:0], seed[31:16]}, 24 - i, rd);
      check(wrCount - cnt0, 1 - i);
      if (i == 0)
        check(wrWord, {seed[6:0], seed[31:16]});
    end
    host.spiFrame({1'h1, 7'h2a, 16'h0}, 12, rd);
    check(doutOe, 0);
    for (i = 0; i < 3; i = i + 1)
    begin
      seed = xs(seed);
      ex = rdModel(seed[6:0]);
      host.spiFrame({1'h1, seed[6:0], seed[31:16]}, 24, rd);
      check(rd, {4'hf, ex[11:0]});
    end
    $display("four-wire test done");
    wrap_up;
  end
endmodule
bind srap_top srap_asserts chk (.clk(clk), .rst(rst), .serialClkIn(serialClkIn), .serialDataIn(serialDataIn),
  .csN(csN), .sdaOe(sdaOe), .doutOut(doutOut), .doutOe(doutOe), .regWrStb(regWrStb), .regRdStb(regRdStb),
  .hsModeActive(hsModeActive), .modeSpiActive(modeSpiActive));
